//--- logic/epi_pkg.sv
`default_nettype none
package epi_pkg;
    // Register indices on the plain register port (our choice, no offsets printed)
    localparam logic [3:0] REG_SENSE_CTRL  = 4'h0;
    localparam logic [3:0] REG_EXT_MASK    = 4'h1;
    localparam logic [3:0] REG_EXT_FLAGS   = 4'h2;
    localparam logic [3:0] REG_GRP_ENABLE  = 4'h3;
    localparam logic [3:0] REG_GRP_FLAGS   = 4'h4;
    localparam logic [3:0] REG_GRP0_MASK   = 4'h5;
    localparam logic [3:0] REG_GRP1_MASK   = 4'h6;
    localparam logic [3:0] REG_GRP2_MASK   = 4'h7;
    localparam logic [3:0] REG_GRP3_MASK   = 4'h8;
    localparam logic [3:0] REG_IRQ_STATUS  = 4'h9;
    localparam logic [3:0] REG_IRQ_MASK    = 4'hA;

    // Field positions
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;
    localparam int EXT_A_BIT   = 0;
    localparam int EXT_B_BIT   = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Pin, group and vector counts
    localparam int NUM_PINS   = 28;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_VEC    = 6;

    // Sense modes
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_ANY_EDGE  = 2'b01,
        SENSE_FALLING   = 2'b10,
        SENSE_RISING    = 2'b11
    } epi_sense_t;

    // Register port request bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } epi_req_t;
endpackage
`default_nettype wire

//--- logic/epi_top.sv
// Behaviour
// - Sense field bits 3:2 select trigger B
// - Sense field bits 1:0 select trigger A
// - Pins sampled; one-cycle pulses register edges
// - Unused register bits read zero
// - Ext enables gated by global enable; WAKE_O ignores global enable
// - Pin activity counts regardless of direction
// - Triggered edge sets ext flag bit
// - Flag cleared on ack or write-one
// - Level mode flag always reads clear
// - Group enables gated by global enable; WAKE_O ignores global enable
// - Pins 27:24,23:16,15:8,7:0 form groups
// - Per-pin masks gate group contribution
// - Change in groups 3..1 sets flag
// - Change in group 0 sets flag
// - Level path wakes from raw pin, change path from synced pins
// - Pin masks reset zero, gate detection
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module epi_top (
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    input  wire logic [1:0]  EXT_PIN_I,
    input  wire logic [27:0] CHG_PIN_I,
    input  wire logic        GLOBAL_EN_I,
    input  wire logic [5:0]  VEC_ACK_I,
    output logic      [5:0]  VEC_REQ_O,
    output logic             WAKE_O,
    output logic             IRQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////
    epi_pkg::epi_req_t req;              // Bundled register request
    logic [3:0]  sense_q;                // Sense fields for A and B
    logic [1:0]  ext_en_q;               // External request enables
    logic [1:0]  ext_flag_q;             // External request flags
    logic [3:0]  grp_en_q;               // Group enables
    logic [3:0]  grp_flag_q;             // Group flags
    logic [7:0]  pin_mask_q [4];         // Per-pin masks, one per group
    logic [5:0]  irq_stat_q;             // Sticky summary status
    logic [5:0]  irq_mask_q;             // Summary interrupt mask
    logic [1:0]  ext_s1_q;               // Sync stage one, ext pins
    logic [1:0]  ext_s2_q;               // Sync stage two, ext pins
    logic [1:0]  ext_old_q;              // Previous synchronised ext value
    logic [27:0] chg_s1_q;               // Sync stage one, change pins
    logic [27:0] chg_s2_q;               // Sync stage two, change pins
    logic [27:0] chg_old_q;              // Previous synchronised change value
    logic [1:0]  ext_hit;                // Edge trigger per ext request
    logic [1:0]  ext_lvl;                // Level mode selected
    logic [1:0]  ext_low_async;          // Raw low level, wake path
    logic [31:0] chg_diff;               // Masked changes, padded to 32
    logic [3:0]  grp_hit;                // Change seen per group
    logic [31:0] chg_mask_all;           // Masks packed per pin
    logic [31:0] chg_raw_diff;           // Raw pin change vs last value
    logic [1:0]  ext_clr;                // Clear strobes ext flags
    logic [3:0]  grp_clr;                // Clear strobes group flags
    logic [5:0]  vec_pend;               // Pending request per vector
    logic [5:0]  vec_go;                 // Pending and enabled

    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    ////////////////////////////////////////////////////////////////////////
    // Two-flop sync, pins read regardless of their direction
    // Stages reset to the idle high level of the pins, so that
    // leaving reset never looks like a falling edge or a change.
    // Only the second stage is read by the compare logic; the
    // first stage may go metastable and feeds nothing else.
    // Pulses shorter than one clock may slip between samples.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ext_s1_q  <= 2'h3;
            ext_s2_q  <= 2'h3;
            ext_old_q <= 2'h3;
            chg_s1_q  <= 28'hFFF_FFFF;
            chg_s2_q  <= 28'hFFF_FFFF;
            chg_old_q <= 28'hFFF_FFFF;
        end else begin
            ext_s1_q  <= EXT_PIN_I;
            ext_s2_q  <= ext_s1_q;
            ext_old_q <= ext_s2_q;
            chg_s1_q  <= CHG_PIN_I;
            chg_s2_q  <= chg_s1_q;
            chg_old_q <= chg_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge and change detection
    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            // Trigger decode per sense field
            // Edges compare the synchronised sample with the one before,
            // so an edge is seen once, two clocks after the pin moves.
            // Level mode never raises an edge hit; it requests directly.
            always_comb begin
                ext_lvl[gi] = (sense_q[2*gi +: 2] == epi_pkg::SENSE_LOW_LEVEL);
                unique case (epi_pkg::epi_sense_t'(sense_q[2*gi +: 2]))
                    epi_pkg::SENSE_LOW_LEVEL: ext_hit[gi] = 1'b0;
                    epi_pkg::SENSE_ANY_EDGE:  ext_hit[gi] = ext_s2_q[gi] ^ ext_old_q[gi];
                    epi_pkg::SENSE_FALLING:   ext_hit[gi] = ext_old_q[gi] & ~ext_s2_q[gi];
                    epi_pkg::SENSE_RISING:    ext_hit[gi] = ~ext_old_q[gi] & ext_s2_q[gi];
                endcase
            end
            // Raw level path bypasses the synchroniser for wake
            assign ext_low_async[gi] = ext_lvl[gi] & ~EXT_PIN_I[gi] & ext_en_q[gi];
        end
        for (gi = 0; gi < 4; gi++) begin : g_grp
            // Masks per pin, group 3 upper bits unused
            assign chg_mask_all[8*gi +: 8] = pin_mask_q[gi];
            assign grp_hit[gi] = |chg_diff[8*gi +: 8];
        end
    endgenerate

    assign chg_raw_diff = {4'h0, chg_s2_q ^ chg_old_q};
    assign chg_diff     = chg_raw_diff & chg_mask_all & {4'h0, 28'hFFF_FFFF};

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    ////////////////////////////////////////////////////////////////////////
    // Control registers, reserved bits never stored
    // Unmapped indices fall through the default and are ignored.
    // Group 3 has only four pins, so its upper mask nibble is kept zero.
    // Writes take effect on the edge that samples the strobe.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sense_q       <= 4'h0;
            ext_en_q      <= 2'h0;
            grp_en_q      <= 4'h0;
            irq_mask_q    <= 6'h00;
            pin_mask_q[0] <= epi_pkg::RST_BYTE;
            pin_mask_q[1] <= epi_pkg::RST_BYTE;
            pin_mask_q[2] <= epi_pkg::RST_BYTE;
            pin_mask_q[3] <= epi_pkg::RST_BYTE;
        end else if (req.wr) begin
            unique case (req.addr)
                epi_pkg::REG_SENSE_CTRL: sense_q <= req.wdata[3:0];
                epi_pkg::REG_EXT_MASK:   ext_en_q <= req.wdata[1:0];
                epi_pkg::REG_GRP_ENABLE: grp_en_q <= req.wdata[3:0];
                epi_pkg::REG_GRP0_MASK:  pin_mask_q[0] <= req.wdata;
                epi_pkg::REG_GRP1_MASK:  pin_mask_q[1] <= req.wdata;
                epi_pkg::REG_GRP2_MASK:  pin_mask_q[2] <= req.wdata;
                epi_pkg::REG_GRP3_MASK:  pin_mask_q[3] <= {4'h0, req.wdata[3:0]};
                epi_pkg::REG_IRQ_MASK:   irq_mask_q <= req.wdata[5:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request flags
    ////////////////////////////////////////////////////////////////////////
    // Clear by vector acknowledge or write-one
    // Writing zero to a flag bit leaves it untouched.
    // An event in the same cycle as a clear keeps the flag set,
    // so a request arriving during the handler is never lost.
    // Level mode holds the external flag at zero at all times.
    assign ext_clr = VEC_ACK_I[1:0] |
                     ({2{req.wr && req.addr == epi_pkg::REG_EXT_FLAGS}} & req.wdata[1:0]);
    assign grp_clr = VEC_ACK_I[5:2] |
                     ({4{req.wr && req.addr == epi_pkg::REG_GRP_FLAGS}} & req.wdata[3:0]);

    // Set wins over clear; level mode forces the flag clear
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ext_flag_q <= 2'h0;
            grp_flag_q <= 4'h0;
        end else begin
            ext_flag_q <= ((ext_flag_q & ~ext_clr) | ext_hit) & ~ext_lvl;
            grp_flag_q <= (grp_flag_q & ~grp_clr) | grp_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector requests
    ////////////////////////////////////////////////////////////////////////
    // Level mode requests while the synchronised pin stays low
    // The request drops the cycle after its acknowledge, even if the
    // flag is set again, so one acknowledge never counts twice.
    // Wake uses the raw pin in level mode but is registered on CLK_I, so it needs the clock.
    assign vec_pend = {grp_flag_q, ext_flag_q | (ext_lvl & ~ext_s2_q)};
    assign vec_go   = vec_pend & {grp_en_q, ext_en_q} & {6{GLOBAL_EN_I}};

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            VEC_REQ_O <= 6'h00;
            WAKE_O    <= 1'b0;
        end else begin
            VEC_REQ_O <= vec_go & ~VEC_ACK_I;
            WAKE_O    <= |ext_low_async | |(grp_hit & grp_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Summary interrupt
    ////////////////////////////////////////////////////////////////////////
    // Sticky status set by each raised vector request, write-one clear
    // A request present during the clear sets the bit again.
    // The output is the OR of unmasked status bits, one clock later.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            irq_stat_q <= 6'h00;
        end else begin
            irq_stat_q <= (irq_stat_q &
                ~({6{req.wr && req.addr == epi_pkg::REG_IRQ_STATUS}} & req.wdata[5:0])) | vec_go;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    ////////////////////////////////////////////////////////////////////////
    // Data one cycle after the read strobe, zero otherwise
    // Reserved bits are padded with zeros on every read.
    // Reads have no side effects; flags clear only on write-one, acknowledge or, for ext flags, level mode.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                epi_pkg::REG_SENSE_CTRL: RDATA_O <= {4'h0, sense_q};
                epi_pkg::REG_EXT_MASK:   RDATA_O <= {6'h00, ext_en_q};
                epi_pkg::REG_EXT_FLAGS:  RDATA_O <= {6'h00, ext_flag_q};
                epi_pkg::REG_GRP_ENABLE: RDATA_O <= {4'h0, grp_en_q};
                epi_pkg::REG_GRP_FLAGS:  RDATA_O <= {4'h0, grp_flag_q};
                epi_pkg::REG_GRP0_MASK:  RDATA_O <= pin_mask_q[0];
                epi_pkg::REG_GRP1_MASK:  RDATA_O <= pin_mask_q[1];
                epi_pkg::REG_GRP2_MASK:  RDATA_O <= pin_mask_q[2];
                epi_pkg::REG_GRP3_MASK:  RDATA_O <= pin_mask_q[3];
                epi_pkg::REG_IRQ_STATUS: RDATA_O <= {2'h0, irq_stat_q};
                epi_pkg::REG_IRQ_MASK:   RDATA_O <= {2'h0, irq_mask_q};
                default:                 RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_rise_sets_flag: assert property (
        (sense_q[3:2] == 2'b11 && $rose(ext_s2_q[1]) && !$past(ext_s2_q[1]) && $stable(sense_q))
        |=> ext_flag_q[1]) else $error("rising edge on B did not set flag");
    a_fall_sets_flag: assert property (
        (sense_q[1:0] == 2'b10 && ext_old_q[0] && !ext_s2_q[0]) |=> ext_flag_q[0] || ext_lvl[0])
        else $error("falling edge on A did not set flag");
    a_pulse_caught: assert property (
        (sense_q[1:0] == 2'b01 && $stable(sense_q) && $changed(EXT_PIN_I[0])) |-> ##3 ext_flag_q[0])
        else $error("pin change on A missed");
    a_resv_zero: assert property (
        $past(req.rd) && $past(req.addr) == epi_pkg::REG_EXT_FLAGS |-> RDATA_O[7:2] == 6'h00)
        else $error("reserved flag bits not zero");
    a_global_gate: assert property (
        !GLOBAL_EN_I |=> VEC_REQ_O == 6'h00) else $error("request without global enable");
    a_w1c_clear: assert property (
        (req.wr && req.addr == epi_pkg::REG_GRP_FLAGS && req.wdata[0] && !grp_hit[0]) |=> !grp_flag_q[0])
        else $error("write one did not clear group flag");
    a_level_clear: assert property (
        ext_lvl[1] |=> !ext_flag_q[1] || !$stable(sense_q)) else $error("level mode flag set");
    a_mask_gates: assert property (
        (pin_mask_q[2] == 8'h00) |-> !grp_hit[2]) else $error("masked group raised change");
    a_grp_set: assert property (
        grp_hit[3] |=> grp_flag_q[3]) else $error("group change did not set flag");
    a_ack_drops: assert property (
        VEC_ACK_I[4] && !grp_hit[2] |=> !grp_flag_q[2]) else $error("ack did not clear flag");
    a_sync_delay: assert property (
        $changed(CHG_PIN_I[5]) && pin_mask_q[0][5] && $stable(pin_mask_q[0]) |-> ##2 grp_hit[0])
        else $error("change not seen two cycles later");

    ////////////////////////////////////////////////////////////////////////
    // Further checks per mode and field
    ////////////////////////////////////////////////////////////////////////
    // Falling edge on B sets its flag
    a_fall_b_flag: assert property (
        (sense_q[3:2] == 2'b10 && ext_old_q[1] && !ext_s2_q[1]) |=> ext_flag_q[1])
        else $error("falling edge on B did not set flag");

    // Rising edge on A sets its flag
    a_rise_a_flag: assert property (
        (sense_q[1:0] == 2'b11 && !ext_old_q[0] && ext_s2_q[0]) |=> ext_flag_q[0])
        else $error("rising edge on A did not set flag");

    // Any change on B sets its flag
    a_any_b_flag: assert property (
        (sense_q[3:2] == 2'b01 && (ext_old_q[1] != ext_s2_q[1])) |=> ext_flag_q[1])
        else $error("change on B did not set flag");

    // Level mode on A keeps the flag clear
    a_level_a_clr: assert property (
        ext_lvl[0] |=> !ext_flag_q[0]) else $error("level mode flag A set");

    // Reserved sense bits read zero
    a_resv_sense: assert property (
        $past(req.rd) && $past(req.addr) == epi_pkg::REG_SENSE_CTRL |-> RDATA_O[7:4] == 4'h0)
        else $error("reserved sense bits not zero");

    // Reserved group flag bits read zero
    a_resv_gflag: assert property (
        $past(req.rd) && $past(req.addr) == epi_pkg::REG_GRP_FLAGS |-> RDATA_O[7:4] == 4'h0)
        else $error("reserved group flag bits not zero");

    // Upper mask nibble of group 3 stays zero
    a_grp3_resv: assert property (
        pin_mask_q[3][7:4] == 4'h0) else $error("group 3 mask upper bits set");

    // Disabled group never requests
    a_grp_gate: assert property (
        !grp_en_q[1] |=> !VEC_REQ_O[3]) else $error("disabled group requested");

    // Disabled external request never requests
    a_ext_gate: assert property (
        !ext_en_q[0] |=> !VEC_REQ_O[0]) else $error("disabled request A requested");

    // Change in group 0 sets its flag
    a_grp0_set: assert property (
        grp_hit[0] |=> grp_flag_q[0]) else $error("group 0 change did not set flag");

    // Group 1 hit only from its own pins
    a_grp1_pins: assert property (
        grp_hit[1] |-> |(chg_s2_q[15:8] ^ chg_old_q[15:8]))
        else $error("group 1 hit without change on its pins");

    // Acknowledge drops the request next cycle
    a_ack_ext: assert property (
        VEC_ACK_I[0] |=> !VEC_REQ_O[0]) else $error("request A stayed after ack");

    // Enabled low level wakes
    a_wake_level: assert property (
        ext_low_async[0] |=> WAKE_O) else $error("low level did not wake");

    c_ext_edge:  cover property (ext_hit[0] && ext_en_q[0] && GLOBAL_EN_I);
    c_grp_req:   cover property (VEC_REQ_O[5]);
    c_set_clear: cover property (grp_hit[1] && grp_clr[1]);
    c_irq_out:   cover property (IRQ_O);
    c_lvl_req:   cover property (ext_lvl[0] && VEC_REQ_O[0]);

endmodule
`default_nettype wire

//--- test/epi_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far-side source of the external request pins and the change pins
module epi_pin_src (
    input  wire logic        clk_i,
    output logic      [1:0]  ext_o,
    output logic      [27:0] chg_o
);
    // Pins idle high, as with pull-ups fitted
    initial begin
        ext_o = 2'h3;
        chg_o = 28'h0FFF_FFFF;
    end

    // Move one request pin and hold the level for three clocks
    task automatic set_ext(input int idx, input logic val);
        @(posedge clk_i);
        ext_o[idx] <= val;
        repeat (3) @(posedge clk_i);
    endtask

    // Toggle one change pin and hold the new level for three clocks
    task automatic flip_chg(input int idx);
        @(posedge clk_i);
        chg_o[idx] <= ~chg_o[idx];
        repeat (3) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- test/epi_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module epi_tb_top;
    logic        clk, rst_n, wr, rd, gen; // Clock, reset, strobes, global enable
    logic [3:0]  addr;                    // Register index
    logic [7:0]  wdata, rdata, got;       // Bus data
    logic [5:0]  ack, vreq;               // Vector handshake
    logic        wake, irq;               // Wake and interrupt levels
    logic [1:0]  ext;                     // Request pins
    logic [27:0] chg;                     // Change pins
    int          failures, cmp_count, cycles, pin, oth, d;
    int          lo [4] = '{0, 8, 16, 24};                        // Group base pin
    int          nw [4] = '{8, 8, 8, 4};                          // Group width
    int          keep [11] = '{15, 3, 0, 15, 0, 255, 255, 255, 15, 0, 63}; // Writable bits

    ////////////////////////////////////////////////////////////////////////////
    epi_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .EXT_PIN_I(ext), .CHG_PIN_I(chg), .GLOBAL_EN_I(gen), .VEC_ACK_I(ack),
        .VEC_REQ_O(vreq), .WAKE_O(wake), .IRQ_O(irq));
    epi_pin_src i_src (.clk_i(clk), .ext_o(ext), .chg_o(chg));

    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One-cycle write, then a quiet edge so strobes never double up
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    // One-cycle read; data stands only in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 got = rdata;
        chk($sformatf("register %h", a), e, got);
        @(posedge clk);
    endtask
    // Let edges pass and step off the edge before sampling outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, wr, rd, gen, addr, wdata, ack} = '0;
        {failures, cmp_count, cycles} = '0;
        d = $urandom(32'he0a5_248b);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, reserved bits and unmapped places
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00);
        for (int a = 0; a < 12; a++) begin
            d = $urandom_range(255);
            wr_reg(4'(a), 8'(d));
            rd_chk(4'(a), (a < 11) ? 8'(d & keep[a]) : 8'h00);
        end
        for (int a = 0; a < 11; a++) wr_reg(4'(a), 8'h00);
        $display("test registers done");
        // Every sense mode on both request pins, both edges
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr_reg(epi_pkg::REG_SENSE_CTRL, 8'(m << (2 * p)));
                wr_reg(epi_pkg::REG_EXT_FLAGS, 8'h03);
                i_src.set_ext(p, 1'b0);
                rd_chk(epi_pkg::REG_EXT_FLAGS, ((m == 1) || (m == 2)) ? 8'(1 << p) : 8'h00);
                wr_reg(epi_pkg::REG_EXT_FLAGS, 8'h03);
                i_src.set_ext(p, 1'b1);
                rd_chk(epi_pkg::REG_EXT_FLAGS, ((m == 1) || (m == 3)) ? 8'(1 << p) : 8'h00);
            end
        end
        $display("test sense modes done");
        // Enable gating, acknowledge, level mode, wake and interrupt output
        wr_reg(epi_pkg::REG_SENSE_CTRL, 8'h02);
        wr_reg(epi_pkg::REG_EXT_MASK, 8'h01);
        wr_reg(epi_pkg::REG_EXT_FLAGS, 8'h03);
        i_src.set_ext(0, 1'b0);
        settle(1);
        chk("vector request", 8'h00, {2'b00, vreq});
        gen <= 1'b1;
        settle(2);
        chk("vector request", 8'h01, {2'b00, vreq});
        ack <= 6'h01;
        @(posedge clk);
        ack <= 6'h00;
        settle(2);
        chk("vector request", 8'h00, {2'b00, vreq});
        chk("interrupt", 8'h00, {7'h00, irq});
        rd_chk(epi_pkg::REG_EXT_FLAGS, 8'h00);
        i_src.set_ext(0, 1'b1);
        wr_reg(epi_pkg::REG_IRQ_STATUS, 8'h3F);
        wr_reg(epi_pkg::REG_SENSE_CTRL, 8'h00);
        i_src.set_ext(0, 1'b0);
        settle(1);
        chk("vector request", 8'h01, {2'b00, vreq});
        chk("wake", 8'h01, {7'h00, wake});
        rd_chk(epi_pkg::REG_EXT_FLAGS, 8'h00);
        i_src.set_ext(0, 1'b1);
        settle(2);
        chk("vector request", 8'h00, {2'b00, vreq});
        chk("interrupt", 8'h00, {7'h00, irq});
        wr_reg(epi_pkg::REG_IRQ_MASK, 8'h01);
        settle(2);
        chk("interrupt", 8'h01, {7'h00, irq});
        rd_chk(epi_pkg::REG_IRQ_STATUS, 8'h01);
        wr_reg(epi_pkg::REG_IRQ_STATUS, 8'h01);
        settle(2);
        chk("interrupt", 8'h00, {7'h00, irq});
        wr_reg(epi_pkg::REG_EXT_MASK, 8'h00);
        wr_reg(epi_pkg::REG_IRQ_MASK, 8'h00);
        $display("test enables and interrupt done");
        // Pin-change groups: masking, flags, vectors, write-one clear
        for (int g = 0; g < 4; g++) begin
            pin = lo[g] + int'($urandom_range(nw[g] - 1));
            oth = lo[g] + ((pin - lo[g] + 1) % nw[g]);
            wr_reg(epi_pkg::REG_GRP0_MASK + 4'(g), 8'(1 << (pin - lo[g])));
            wr_reg(epi_pkg::REG_GRP_ENABLE, 8'(1 << g));
            i_src.flip_chg(oth);
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'h00);
            i_src.flip_chg(pin);
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'(1 << g));
            settle(1);
            chk("vector request", 8'(1 << (g + 2)), {2'b00, vreq});
            wr_reg(epi_pkg::REG_GRP_FLAGS, 8'h00);
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'(1 << g));
            wr_reg(epi_pkg::REG_GRP_FLAGS, 8'(1 << g));
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'h00);
            i_src.flip_chg(pin);
            ack <= 6'(1 << (g + 2));
            @(posedge clk);
            ack <= 6'h00;
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'h00);
            wr_reg(epi_pkg::REG_GRP0_MASK + 4'(g), 8'h00);
            i_src.flip_chg(pin);
            rd_chk(epi_pkg::REG_GRP_FLAGS, 8'h00);
            wr_reg(epi_pkg::REG_GRP_ENABLE, 8'h00);
        end
        $display("test pin-change groups done");
        stop_test();
    end
endmodule
`default_nettype wire
